// >>> rtl/flash_front.sv
// Purpose: Serial flash instruction front end with request buffer
// Assumes: link pins are asynchronous to core_clk; serial clock at most core_clk/8
// Notes: Array timing lives outside; requests leave through a buffer
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////////////
// Request buffer: flip-flop storage, valid/ready on both sides
module req_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 32,
   parameter int unsigned AW = 5
) (
   input wire logic core_clk, // Core clock
   input wire logic rst_n, // Async reset, active low
   input wire logic in_valid, // Source offers a word
   output logic in_ready, // Space available
   input wire logic [WIDTH-1:0] in_data, // Word in
   output logic out_valid, // Word available
   input wire logic out_ready, // Sink takes a word
   output logic [WIDTH-1:0] out_data // Word out
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage
      logic [AW-1:0] wr; // Write index
      logic [AW-1:0] rd; // Read index
      logic [AW:0] cnt; // Fill count
   } fifo_st_t;
   fifo_st_t st_reg, st_next;
   logic push, pop;

   // Handshakes from honest count
   assign in_ready = (st_reg.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_reg.cnt != '0);
   assign out_data = st_reg.mem[st_reg.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Next-state of buffer
   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.mem[st_reg.wr] = in_data;
         st_next.wr = st_reg.wr + 1'b1;
      end
      if (pop) begin
         st_next.rd = st_reg.rd + 1'b1;
      end
      if (push && !pop) begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end else if (pop && !push) begin
         st_next.cnt = st_reg.cnt - 1'b1;
      end
   end

   // State register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule // req_fifo

//////////////////////////////////////////////////////////////////////////////
module flash_front
   import flash_front_pkg::*;
(
   input wire logic core_clk, // Core clock, 25 MHz
   input wire logic rst_n, // Async reset, active low
   input wire logic cs_n, // Chip select pin, active low
   input wire logic sck, // Serial clock pin
   input wire logic si, // Serial data in pin
   output logic so, // Serial data out
   output logic so_oe, // Serial out enable, high drives
   input wire logic wp_n, // Write-protect pin, active low
   input wire logic busy, // Array busy from write engine
   output logic req_valid, // Write request available
   input wire logic req_ready, // Write engine takes request
   output wr_req_t req_data, // Write request
   output logic [19:0] rd_addr, // Array read address
   input wire logic [7:0] rd_data, // Array read data
   output logic [7:0] status // Status byte view
);
   typedef enum logic [2:0] {
      S_IDLE, S_OPCODE, S_ADDR, S_DUMMY, S_DATA_IN, S_DATA_OUT, S_IGNORE
   } phase_t;
   typedef struct packed {
      logic [1:0] cs_sync; // Select synchroniser
      logic [1:0] sck_sync; // Clock synchroniser
      logic [1:0] si_sync; // Data synchroniser
      logic [1:0] wp_sync; // Write-protect synchroniser
      logic sck_prev; // Last synced clock level
      phase_t phase; // Instruction phase
      logic [2:0] bit_cnt; // Bit within bus cycle
      logic [7:0] shift; // Input shifter
      logic [7:0] opcode; // Current opcode
      logic [1:0] abyte; // Address byte count
      logic [19:0] addr; // Working address
      logic [7:0] out_sh; // Output shifter
      logic so_bit; // Driven output bit
      logic so_en; // Output enable
      logic wel; // Write enable latch
      logic status_write_enable_cmd; // Status write armed
      logic auto_increment_program; // Auto-increment mode
      logic aai_odd; // Second byte of pair pending
      logic [7:0] aai_lo; // Even byte held until select rises
      logic [7:0] aai_hi; // Odd byte held until select rises
      logic aai_hi_v; // Odd byte waits behind the even one
      logic busy_out; // Ready/busy on serial output
      logic [3:0] bp; // Protect level bits
      logic lock; // Protection lock-down
      logic req_v; // Pending request
      wr_req_t req; // Request word
   } core_st_t;
   core_st_t st_reg, st_next;
   logic fifo_ready;
   logic fifo_out_valid;
   wr_req_t fifo_out;
   logic cs_n_s, sck_s, si_s, wp_n_s, rise, fall;
   logic [7:0] byte_in;

   // Protected check for a target address at a given level
   function automatic logic is_protected(input logic [2:0] lvl, input logic [19:0] a);
      logic r;
      r = 1'b1;
      unique case (lvl)
         PL_NONE: r = 1'b0;
         PL_16TH: r = (a >= BASE_16TH);
         PL_8TH: r = (a >= BASE_8TH);
         PL_4TH: r = (a >= BASE_4TH);
         PL_HALF: r = (a >= BASE_HALF);
         default: r = 1'b1;
      endcase
      return r;
   endfunction

   // Synchronised pin views, second stage only
   assign cs_n_s = st_reg.cs_sync[1];
   assign sck_s = st_reg.sck_sync[1];
   assign si_s = st_reg.si_sync[1];
   assign wp_n_s = st_reg.wp_sync[1];
   assign rise = sck_s && !st_reg.sck_prev;
   assign fall = !sck_s && st_reg.sck_prev;
   assign byte_in = {st_reg.shift[6:0], si_s};
   assign so = st_reg.so_bit;
   assign so_oe = st_reg.so_en;
   assign rd_addr = st_reg.addr;
   assign status = {st_reg.lock, st_reg.auto_increment_program, st_reg.bp, st_reg.wel, busy};

   //////////////////////////////////////////////////////////////////////////
   // Instruction sequencer
   always_comb begin
      st_next = st_reg;
      st_next.cs_sync = {st_reg.cs_sync[0], cs_n};
      st_next.sck_sync = {st_reg.sck_sync[0], sck};
      st_next.si_sync = {st_reg.si_sync[0], si};
      st_next.wp_sync = {st_reg.wp_sync[0], wp_n};
      st_next.sck_prev = sck_s;
      // Drop request once buffer accepts it
      if (st_reg.req_v && fifo_ready) begin
         st_next.req_v = 1'b0;
      end
      // odd byte of the pair follows the even one
      if (st_reg.aai_hi_v && !st_reg.req_v) begin
         st_next.aai_hi_v = 1'b0;
         st_next.req.kind = REQ_PROGRAM;
         st_next.req.addr = st_reg.addr | ADDR_ONE;
         st_next.req.data = st_reg.aai_hi;
         st_next.req_v = !is_protected(st_reg.bp[2:0], st_reg.addr | ADDR_ONE);
         st_next.addr = (st_reg.addr | ADDR_ONE) + ADDR_ONE;
      end
      if (cs_n_s) begin
         st_next.phase = S_IDLE;
         st_next.bit_cnt = '0;
         st_next.so_en = 1'b0;
      end else begin
         if (st_reg.phase == S_IDLE) begin
            st_next.phase = S_OPCODE;
            st_next.bit_cnt = '0;
            st_next.so_en = st_reg.busy_out && st_reg.auto_increment_program;
            st_next.so_bit = !busy;
         end
         if (rise && st_reg.phase != S_IDLE) begin
            st_next.shift = byte_in;
            st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
            if (st_reg.bit_cnt == BIT_LAST) begin
               unique case (st_reg.phase)
                  S_OPCODE: begin
                     st_next.opcode = byte_in;
                     st_next.abyte = '0;
                     st_next.phase = S_IGNORE;
                     unique case (byte_in)
                        OP_READ, OP_FAST_READ, OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE,
                        OP_BYTE_PROGRAM, OP_ID_READ_A, OP_ID_READ_B: begin
                           st_next.phase = S_ADDR;
                        end
                        OP_AUTO_INC: begin
                           st_next.phase = st_reg.auto_increment_program ? S_DATA_IN : S_ADDR;
                           st_next.aai_odd = 1'b0;
                        end
                        OP_STATUS_READ: begin
                           st_next.phase = S_DATA_OUT;
                           st_next.out_sh = status;
                        end
                        OP_STATUS_WRITE: st_next.phase = S_DATA_IN;
                        default: st_next.phase = S_IGNORE;
                     endcase
                  end
                  S_ADDR: begin
                     st_next.addr = {st_reg.addr[11:0], byte_in};
                     st_next.abyte = st_reg.abyte + 1'b1;
                     if (st_reg.abyte == ABYTE_LAST) begin
                        unique case (st_reg.opcode)
                           OP_READ: st_next.phase = S_DATA_OUT;
                           OP_FAST_READ: st_next.phase = S_DUMMY;
                           OP_ID_READ_A, OP_ID_READ_B: st_next.phase = S_DATA_OUT;
                           default: st_next.phase = S_DATA_IN;
                        endcase
                     end
                  end
                  S_DUMMY: st_next.phase = S_DATA_OUT;
                  S_DATA_IN: begin
                     st_next.req.data = byte_in;
                     if (st_reg.opcode == OP_AUTO_INC) begin
                        // hold the pair until select rises, so a cut frame writes nothing
                        st_next.aai_odd = !st_reg.aai_odd;
                        if (st_reg.aai_odd) begin
                           st_next.aai_hi = byte_in;
                           st_next.phase = S_IGNORE;
                        end else begin
                           st_next.aai_lo = byte_in;
                        end
                     end else if (st_reg.opcode == OP_STATUS_WRITE) begin
                        st_next.phase = S_IGNORE;
                     end else begin
                        st_next.req.addr = st_reg.addr;
                        st_next.req.kind = REQ_PROGRAM;
                        st_next.phase = S_IGNORE;
                     end
                  end
                  S_DATA_OUT: ;
                  S_IGNORE: ;
                  default: st_next.phase = S_IGNORE;
               endcase
            end
         end
         if (fall && st_reg.phase == S_DATA_OUT) begin
            st_next.so_en = 1'b1;
            st_next.so_bit = st_reg.out_sh[BYTE_BITS-1];
            st_next.out_sh = {st_reg.out_sh[6:0], 1'b0};
            if (st_reg.bit_cnt == '0) begin
               unique case (st_reg.opcode)
                  OP_STATUS_READ: begin
                     st_next.so_bit = status[ST_LOCK];
                     st_next.out_sh = {status[6:0], 1'b0};
                  end
                  OP_ID_READ_A, OP_ID_READ_B: begin
                     st_next.so_bit = st_reg.addr[0] ? PART_CODE[7] : MAKER_CODE[7];
                     st_next.out_sh = st_reg.addr[0] ? {PART_CODE[6:0], 1'b0} : {MAKER_CODE[6:0], 1'b0};
                  end
                  default: begin
                     st_next.so_bit = rd_data[BYTE_BITS-1];
                     st_next.out_sh = {rd_data[6:0], 1'b0};
                     st_next.addr = (st_reg.addr == ADDR_TOP) ? ADDR_ZERO : st_reg.addr + ADDR_ONE;
                  end
               endcase
            end
         end
      end
      // Commit on select rise after complete instruction; phase drops to idle on the same clock edge
      if (cs_n_s && st_reg.phase != S_IDLE && st_reg.bit_cnt == '0) begin
         unique case (st_reg.opcode)
            OP_WRITE_ENABLE: st_next.wel = 1'b1;
            OP_WRITE_DISABLE: begin
               st_next.wel = 1'b0;
               st_next.auto_increment_program = 1'b0;
            end
            OP_STATUS_WRITE_ENABLE_CMD: st_next.status_write_enable_cmd = 1'b1;
            OP_BUSY_ON: st_next.busy_out = 1'b1;
            OP_BUSY_OFF: st_next.busy_out = 1'b0;
            OP_STATUS_WRITE: begin
               if (st_reg.phase == S_IGNORE && (st_reg.wel || st_reg.status_write_enable_cmd)) begin
                  // lock honoured only with write-protect low
                  if (!(st_reg.lock && !wp_n_s)) begin
                     st_next.bp = st_reg.shift[ST_BP_HI:ST_BP_LO];
                     st_next.lock = st_reg.shift[ST_LOCK];
                  end
                  st_next.wel = 1'b0;
                  st_next.status_write_enable_cmd = 1'b0;
               end
            end
            OP_BYTE_PROGRAM: begin
               if (st_reg.phase == S_IGNORE && st_reg.wel) begin
                  st_next.req_v = !is_protected(st_reg.bp[2:0], st_reg.addr);
                  st_next.wel = 1'b0;
               end
            end
            OP_AUTO_INC: begin
               if (st_reg.phase == S_IGNORE && st_reg.wel) begin
                  // even byte leaves now, odd byte next
                  st_next.auto_increment_program = 1'b1;
                  st_next.req.kind = REQ_PROGRAM;
                  st_next.req.addr = st_reg.addr & ~ADDR_ONE;
                  st_next.req.data = st_reg.aai_lo;
                  st_next.req_v = !is_protected(st_reg.bp[2:0], st_reg.addr & ~ADDR_ONE);
                  st_next.aai_hi_v = 1'b1;
               end
            end
            OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE: begin
               if (st_reg.phase == S_DATA_IN && st_reg.wel) begin
                  st_next.req.addr = st_reg.addr;
                  st_next.req.kind = (st_reg.opcode == OP_SECTOR_ERASE) ? REQ_SECTOR :
                     (st_reg.opcode == OP_BLOCK32_ERASE) ? REQ_BLOCK32 : REQ_BLOCK64;
                  st_next.req_v = !is_protected(st_reg.bp[2:0], st_reg.addr);
                  st_next.wel = 1'b0;
               end
            end
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
               if (st_reg.wel) begin
                  st_next.req.kind = REQ_CHIP;
                  st_next.req.addr = ADDR_ZERO;
                  st_next.req_v = (st_reg.bp == '0);
                  st_next.wel = 1'b0;
               end
            end
            default: ;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // State register with protection reset values
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
         st_reg.cs_sync <= 2'h3;
         st_reg.phase <= S_IDLE;
         st_reg.bp <= BP_RESET;
         st_reg.lock <= LOCK_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign req_valid = fifo_out_valid;
   assign req_data = fifo_out;

   // Request buffer toward the write engine
   req_fifo #(
      .WIDTH(REQ_W),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_req_fifo (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .in_valid(st_reg.req_v),
      .in_ready(fifo_ready),
      .in_data(st_reg.req),
      .out_valid(fifo_out_valid),
      .out_ready(req_ready),
      .out_data(fifo_out)
   );
endmodule // flash_front

// >>> rtl/flash_front_pkg.sv
// Purpose: Shared constants and carrier types for the serial flash front end
// Assumes: 20-bit array address, 8-bit bus cycles
// Notes: Opcodes, status bit positions and reset values live here
package flash_front_pkg;
   // Bus cycle framing
   localparam int unsigned BYTE_BITS = 8;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam int unsigned ADDR_BYTES = 3;
   localparam int unsigned ARRAY_AW = 20;
   localparam logic [19:0] ADDR_TOP = 20'hfffff;
   localparam logic [19:0] ADDR_ZERO = 20'h00000;
   localparam logic [19:0] ADDR_ONE = 20'h00001;
   localparam logic [1:0] ABYTE_LAST = 2'h2;
   // Opcodes
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0b;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
   localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
   localparam logic [7:0] OP_BYTE_PROGRAM = 8'h02;
   localparam logic [7:0] OP_AUTO_INC = 8'had;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE_ENABLE_CMD = 8'h50;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_ID_READ_A = 8'h90;
   localparam logic [7:0] OP_ID_READ_B = 8'hab;
   localparam logic [7:0] OP_BUSY_ON = 8'h70;
   localparam logic [7:0] OP_BUSY_OFF = 8'h80;
   // Identity codes, values are arbitrary
   localparam logic [7:0] MAKER_CODE = 8'h5a;
   localparam logic [7:0] PART_CODE = 8'ha5;
   // Status register bit positions
   localparam int unsigned ST_BUSY = 0;
   localparam int unsigned ST_WEL = 1;
   localparam int unsigned ST_BP_LO = 2;
   localparam int unsigned ST_BP_HI = 5;
   localparam int unsigned ST_AAI = 6;
   localparam int unsigned ST_LOCK = 7;
   // Reset values of protection fields
   localparam logic [3:0] BP_RESET = 4'h7;
   localparam logic LOCK_RESET = 1'b0;
   // Protect level decode values
   localparam logic [2:0] PL_NONE = 3'h0;
   localparam logic [2:0] PL_16TH = 3'h1;
   localparam logic [2:0] PL_8TH = 3'h2;
   localparam logic [2:0] PL_4TH = 3'h3;
   localparam logic [2:0] PL_HALF = 3'h4;
   localparam logic [19:0] BASE_16TH = 20'hf0000;
   localparam logic [19:0] BASE_8TH = 20'he0000;
   localparam logic [19:0] BASE_4TH = 20'hc0000;
   localparam logic [19:0] BASE_HALF = 20'h80000;
   // Buffer geometry
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned FIFO_AW = 5;
   // Write request kinds
   typedef enum logic [2:0] {
      REQ_PROGRAM, REQ_SECTOR, REQ_BLOCK32, REQ_BLOCK64, REQ_CHIP, REQ_STATUS
   } req_kind_t;
   // One array write request
   typedef struct packed {
      req_kind_t kind;
      logic [19:0] addr;
      logic [7:0] data;
   } wr_req_t;
   localparam int unsigned REQ_W = $bits(wr_req_t);
endpackage

// >>> testbench/flash_front_monitor.sv
// Purpose: Port-level checker for the flash front end
// Assumes: Bound to flash_front, single core clock domain
// Notes: Link pins are seen raw, so select edges lead the synchronised view
`timescale 1ns/10ps
module flash_front_monitor
   import flash_front_pkg::*;
(
   input wire logic core_clk, // Core clock
   input wire logic rst_n, // Async reset, active low
   input wire logic cs_n, // Select pin, active low
   input wire logic so_oe, // Serial out enable
   input wire logic wp_n, // Write-protect pin, active low
   input wire logic req_valid, // Request available
   input wire logic req_ready, // Request taken
   input wire wr_req_t req_data, // Request word
   input wire logic [7:0] status // Status byte
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   //////////////////////////////////////////////////////////////////////////////
   // Select idle for a while
   sequence s_deselected;
      cs_n [*8];
   endsequence
   // Lock effective for a while
   sequence s_locked;
      (!wp_n && status[ST_LOCK]) [*4];
   endsequence
   chk_reset_protect: assert property ($rose(rst_n) |-> status[4:2] == 3'h7)
      else $error("protect bits not all ones after reset");
   chk_reset_lock: assert property ($rose(rst_n) |-> !status[ST_LOCK] && !status[ST_BP_HI])
      else $error("lock or top protect bit set after reset");
   chk_locked_hold: assert property (s_locked |=> $stable({status[7], status[5:2]}))
      else $error("protection changed while locked");
   chk_quiet_idle: assert property (s_deselected |-> !so_oe)
      else $error("serial out driven while deselected");
   chk_oe_after_sel: assert property ($rose(so_oe) |-> !$past(cs_n))
      else $error("serial out enabled without select");
   chk_req_at_rise: assert property ($rose(req_valid) |-> $past(cs_n))
      else $error("request raised inside a frame");
   chk_req_hold: assert property (req_valid && !req_ready |=> req_valid && $stable(req_data))
      else $error("stalled request not held");
   chk_prot_program: assert property (req_valid && req_data.kind == REQ_PROGRAM && status[4:2] == PL_16TH
      |-> req_data.addr < BASE_16TH)
      else $error("program request inside protected range");
endmodule // flash_front_monitor

bind flash_front flash_front_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .so_oe(so_oe),
   .wp_n(wp_n), .req_valid(req_valid), .req_ready(req_ready), .req_data(req_data), .status(status));

// >>> testbench/flash_front_tb_top.sv
// Purpose: Self-checking bench for the flash front end
// Assumes: Host model owns the link pins; array data is address xor 5c
// Notes: Requests are taken one at a time so each is compared alone
`timescale 1ns/10ps
module flash_front_tb_top;
   import flash_front_pkg::*;
   logic core_clk, rst_n, wp_n, req_ready, so, so_oe, req_valid, cs_n, sck, si, busy;
   wr_req_t req_data;
   logic [19:0] rd_addr;
   logic [7:0] rd_data, status, rx_last, rxq[$];
   logic [7:0] eop[5] = '{OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
   req_kind_t ekd[5] = '{REQ_SECTOR, REQ_BLOCK32, REQ_BLOCK64, REQ_CHIP, REQ_CHIP};
   int n_mismatch = 0;
   int checked = 0;
   assign rd_data = rd_addr[7:0] ^ 8'h5c;
   flash_front dut (.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe),
      .wp_n(wp_n), .busy(busy), .req_valid(req_valid), .req_ready(req_ready), .req_data(req_data),
      .rd_addr(rd_addr), .rd_data(rd_data), .status(status));
   spi_host_model host (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));
   //////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One framed transfer; the last sent byte may be cut short
   task automatic frame(input logic [7:0] tx[$], input int nrd, input int nl = 8);
      logic [7:0] rx;
      rxq = {};
      @(posedge core_clk) #1;
      host.sel(1'b1);
      foreach (tx[i]) host.xfer(tx[i], (i == tx.size() - 1) ? nl : 8, rx);
      rx_last = rx;
      repeat (nrd) begin
         host.xfer(8'h00, 8, rx);
         rxq.push_back(rx);
      end
      host.sel(1'b0);
      repeat (4) @(posedge core_clk) #1;
   endtask
   // Wait for a request, compare whole word or kind alone, then accept it
   task automatic take(input logic [31:0] exp, input logic whole);
      int n;
      n = 0;
      while (req_valid !== 1'b1 && n < 200) begin
         @(posedge core_clk) #1;
         n++;
      end
      chk(whole ? req_data : {req_data.kind, 28'h0}, exp);
      req_ready = 1'b1;
      @(posedge core_clk) #1;
      req_ready = 1'b0;
      @(posedge core_clk) #1;
   endtask
   task automatic none();
      repeat (40) @(posedge core_clk) #1;
      chk(req_valid, 1'b0);
   endtask
   task automatic wen();
      frame({OP_WRITE_ENABLE}, 0);
   endtask
   task automatic prog(input logic [23:0] a, input logic [7:0] d);
      frame({OP_BYTE_PROGRAM, a[23:16], a[15:8], a[7:0], d}, 0);
   endtask
   // Status write, draining any status request it leaves behind
   task automatic sw(input logic [7:0] v);
      wen();
      frame({OP_STATUS_WRITE, v}, 0);
      repeat (8) @(posedge core_clk) #1;
      if (req_valid === 1'b1 && req_data.kind === REQ_STATUS) begin
         req_ready = 1'b1;
         @(posedge core_clk) #1;
         req_ready = 1'b0;
      end
   endtask
   //////////////////////////////////////////////////////////////////////////////
   // Core clock, 40 ns period
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // Watchdog
   initial begin
      #2_000_000;
      n_mismatch++;
      complete_run();
   end
   // Main sequence
   initial begin
      rst_n = 1'b0;
      wp_n = 1'b1;
      busy = 1'b0;
      req_ready = 1'b0;
      repeat (8) @(posedge core_clk) #1;
      rst_n = 1'b1;
      repeat (4) @(posedge core_clk) #1;
      chk(status, 8'h1c);
      frame({OP_STATUS_READ}, 2);
      chk({rxq[0], rxq[1]}, 16'h1c1c);
      frame({OP_ID_READ_A, 8'h00, 8'h00, 8'h00}, 2);
      chk({rxq[0], rxq[1]}, {MAKER_CODE, MAKER_CODE});
      frame({OP_ID_READ_B, 8'h00, 8'h00, 8'h01}, 1);
      chk(rxq[0], PART_CODE);
      sw(8'h00);
      chk(status[5:2], 4'h0);
      wen();
      prog(24'hfabcde, 8'h3c);
      take({REQ_PROGRAM, 20'habcde, 8'h3c}, 1'b1);
      prog(24'h000100, 8'h01);
      none();
      wen();
      frame({8'h3e, OP_BYTE_PROGRAM, 8'h00, 8'h01, 8'h00, 8'h55}, 0);
      none();
      frame({OP_BYTE_PROGRAM, 8'h00, 8'h01, 8'h00, 8'h55}, 0, 4);
      none();
      for (int i = 0; i < 5; i++) begin
         wen();
         if (i < 3) frame({eop[i], 8'h01, 8'h23, 8'h45}, 0);
         else frame({eop[i]}, 0);
         take({ekd[i], 28'h0}, 1'b0);
      end
      sw(8'h04);
      wen();
      frame({OP_CHIP_ERASE_A}, 0);
      none();
      wen();
      prog(24'h0f0000, 8'h66);
      none();
      wen();
      prog(24'h0effff, 8'h67);
      take({REQ_PROGRAM, 20'heffff, 8'h67}, 1'b1);
      sw(8'h00);
      frame({OP_BUSY_ON}, 0);
      wen();
      frame({OP_AUTO_INC, 8'h00, 8'h00, 8'h10, 8'h11, 8'h22}, 0);
      take({REQ_PROGRAM, 20'h00010, 8'h11}, 1'b1);
      take({REQ_PROGRAM, 20'h00011, 8'h22}, 1'b1);
      frame({OP_AUTO_INC, 8'h33, 8'h44}, 0);
      chk(rx_last, 8'hff);
      take({REQ_PROGRAM, 20'h00012, 8'h33}, 1'b1);
      take({REQ_PROGRAM, 20'h00013, 8'h44}, 1'b1);
      busy = 1'b1;
      frame({OP_WRITE_DISABLE}, 0);
      chk(rx_last, 8'h00);
      busy = 1'b0;
      frame({OP_BUSY_OFF}, 0);
      wp_n = 1'b0;
      sw(8'h84);
      chk({status[7], status[5:2]}, 5'h11);
      sw(8'h00);
      chk({status[7], status[5:2]}, 5'h11);
      wp_n = 1'b1;
      sw(8'h00);
      chk({status[7], status[5:2]}, 5'h00);
      frame({OP_READ, 8'h0f, 8'hff, 8'hfe}, 3);
      chk({rxq[0], rxq[1], rxq[2]}, {8'hfe ^ 8'h5c, 8'hff ^ 8'h5c, 8'h00 ^ 8'h5c});
      frame({OP_FAST_READ, 8'h00, 8'h00, 8'h20, 8'h00}, 2);
      chk({rxq[0], rxq[1]}, {8'h20 ^ 8'h5c, 8'h21 ^ 8'h5c});
      wen();
      prog(24'h000200, 8'ha1);
      wen();
      prog(24'h000201, 8'ha2);
      chk(req_valid, 1'b1);
      take({REQ_PROGRAM, 20'h00200, 8'ha1}, 1'b1);
      take({REQ_PROGRAM, 20'h00201, 8'ha2}, 1'b1);
      rst_n = 1'b0;
      repeat (2) @(posedge core_clk) #1;
      rst_n = 1'b1;
      repeat (4) @(posedge core_clk) #1;
      chk(status, 8'h1c);
      complete_run();
   end
endmodule // flash_front_tb_top

// >>> testbench/spi_host_model.sv
// Purpose: Mode 0 serial host driving the flash front end
// Assumes: 320 ns link period, bits MSB first
// Notes: Clock stands low between frames; released data shows its inverse
`timescale 1ns/10ps
module spi_host_model (
   output logic cs_n, // Select, active low
   output logic sck, // Link clock, idles low
   output logic si, // Data to device
   input wire logic so, // Data from device
   input wire logic so_oe // Device drives so
);
   localparam int HALF = 160; // Half link period in ns
   // Idle levels at time zero
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end
   // select framing, held low for the whole frame
   task automatic sel(input logic lo);
      #HALF;
      cs_n = !lo;
      if (!lo) si = !si;
      #HALF;
   endtask
   // nb bits of a cycle, up to eight, sampled by the device at the rise
   task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
      for (int i = 7; i > 7 - nb; i--) begin
         si = tx[i];
         #HALF;
         sck = 1'b1;
         rx = {rx[6:0], so_oe ? so : 1'bx};
         #HALF;
         sck = 1'b0;
      end
   endtask
endmodule // spi_host_model
